/* rtl/lcd_pkg.sv */
// Purpose: Constants and types for the PHY line-coding datapath
// Assumes: Single 20 MHz clock; 100M path handled one bit per clock
// Notes:   Times are given in ns and turned into cycle counts here
package lcd_pkg;
   localparam int CLK_NS = 50;

   // Nibble timer limits: five bit slots at 100M, eight half-bits at 10M
   localparam logic [2:0] NIB100_LAST = 3'h4;
   localparam logic [2:0] NIB10_LAST  = 3'h7;

   localparam logic [4:0] CG_IDLE = 5'h1F;
   localparam logic [4:0] CG_J    = 5'h18;
   localparam logic [4:0] CG_K    = 5'h11;
   localparam logic [4:0] CG_T    = 5'h0D;
   localparam logic [4:0] CG_R    = 5'h07;
   localparam logic [4:0] CG_H    = 5'h04;
   localparam logic [3:0] START_NIB = 4'h5;

   // Data nibble 0..F to code-group
   localparam logic [4:0] CG_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
      5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

   // Eleven-stage key register, taps for x^11 + x^9 + 1
   localparam logic [10:0] SCR_SEED  = 11'h7FF;
   localparam int          SCR_TAP_A = 10;
   localparam int          SCR_TAP_B = 8;
   localparam logic [5:0]  LOCK_MATCHES = 6'h1E;
   localparam logic [3:0]  IDLE_RUN     = 4'hA;

   // Quantizer slicing threshold for the three MLT-3 levels
   localparam logic signed [5:0] MLT_THR = 6'sh10;

   localparam int SYNC_TIMEOUT_NS  = 40000;
   localparam int SYNC_TIMEOUT_CYC = SYNC_TIMEOUT_NS / CLK_NS;
   localparam int JABBER_NS        = 45000000;
   localparam int JABBER_CYC       = JABBER_NS / CLK_NS;
   localparam int PULSE_PERIOD_NS  = 16000000;
   localparam int PULSE_PERIOD_CYC = PULSE_PERIOD_NS / CLK_NS;
   localparam int PULSE_WIDTH_NS   = 100;
   localparam int PULSE_WIDTH_CYC  = (PULSE_WIDTH_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_MAX_NS     = 200;
   localparam int PULSE_MAX_CYC    = PULSE_MAX_NS / CLK_NS;
   localparam int LINK_LOSS_NS     = 100000000;
   localparam int LINK_LOSS_CYC    = LINK_LOSS_NS / CLK_NS;

   typedef enum logic [1:0] {TS_IDLE, TS_K, TS_DATA, TS_R} lcd_tx_state_t;
endpackage

/* rtl/lcd_datapath.sv */
// Purpose: Line-coding datapath of a 10/100 PHY between MII and analog front end
// Assumes: MII and management inputs come from logic on clk_in
// Notes:   100M path advances one line bit per clock; 10M path uses clk_in as
//          the Manchester half-bit clock
`timescale 1ns/1ns
module lcd_datapath #(
   parameter int JABBER_CYC       = lcd_pkg::JABBER_CYC,
   parameter int PULSE_PERIOD_CYC = lcd_pkg::PULSE_PERIOD_CYC,
   parameter int LINK_LOSS_CYC    = lcd_pkg::LINK_LOSS_CYC
)(
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       speed_100_in,
   input  wire logic       descr_bypass_in,
   input  wire logic       tx_en_in,
   input  wire logic       tx_er_in,
   input  wire logic [3:0] txd_in,
   input  wire logic [5:0] rx_sample_in,
   input  wire logic       rx10_line_in,
   input  wire logic       rx10_active_in,
   output logic            tx_nib_take_out,
   output logic            mlt3_pos_out,
   output logic            mlt3_neg_out,
   output logic            tx10_line_out,
   output logic            tx10_drive_out,
   output logic [3:0]      rxd_out,
   output logic            rx_dv_out,
   output logic            rx_er_out,
   output logic            rx_nib_stb_out,
   output logic            crs_out,
   output logic            polarity_reversed_flag_out,
   output logic            link10_up_out,
   output logic            jabber_out,
   output logic            descr_locked_out
);
   if (JABBER_CYC < 2 || PULSE_PERIOD_CYC <= lcd_pkg::PULSE_WIDTH_CYC || LINK_LOSS_CYC < 2)
   begin : g_chk
      $error("lcd_datapath: count parameters too small");
   end

   function automatic logic [4:0] dec5(input logic [4:0] g);
      dec5 = 5'h00;
      for (int i = 0; i < 16; i++)
         if (lcd_pkg::CG_TAB[i] == g)
            dec5 = {1'b1, 4'(i)};
   endfunction

   // Pin synchronisers
   logic [5:0] smp_m_q, smp_q;
   logic [1:0] l10_m_q, l10_q;
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         smp_m_q <= 6'h00;
         smp_q   <= 6'h00;
         l10_m_q <= 2'h0;
         l10_q   <= 2'h0;
      end
      else
      begin
         smp_m_q <= rx_sample_in;
         smp_q   <= smp_m_q;
         l10_m_q <= {rx10_active_in, rx10_line_in};
         l10_q   <= l10_m_q;
      end

   // Nibble timer shared by both speeds
   logic [2:0]  nib_cnt_q, nib_lim;
   logic        nib_last, take_q;
   assign nib_lim  = speed_100_in ? lcd_pkg::NIB100_LAST : lcd_pkg::NIB10_LAST;
   assign nib_last = nib_cnt_q >= nib_lim;
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         nib_cnt_q <= 3'h0;
         take_q    <= 1'b0;
      end
      else
      begin
         nib_cnt_q <= nib_last ? 3'h0 : nib_cnt_q + 3'h1;
         // MAC holds TXD/TX_EN while this is high; they are taken at its closing edge
         take_q    <= (nib_cnt_q == nib_lim - 3'h1);
      end
   assign tx_nib_take_out = take_q;

   // Jabber watchdog
   logic [31:0] jab_cnt_q;
   logic        jab_q, tx_en_eff;
   assign tx_en_eff = tx_en_in & ~jab_q;
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         jab_cnt_q <= 32'h0;
         jab_q     <= 1'b0;
      end
      else if (!tx_en_in)
      begin
         jab_cnt_q <= 32'h0;
         jab_q     <= 1'b0;
      end
      else if (jab_cnt_q == 32'(JABBER_CYC - 1))
         jab_q <= 1'b1;
      else
         jab_cnt_q <= jab_cnt_q + 32'h1;
   assign jabber_out = jab_q;

   // 100M transmit: code-group selection
   lcd_pkg::lcd_tx_state_t ts_q, ts_d;
   logic [4:0] cg_d;
   logic       er_prev_q;
   always_comb
   begin
      cg_d = lcd_pkg::CG_IDLE;
      ts_d = ts_q;
      case (ts_q)
         lcd_pkg::TS_IDLE:
            if (tx_en_eff)
            begin
               cg_d = lcd_pkg::CG_J;
               ts_d = lcd_pkg::TS_K;
            end
         lcd_pkg::TS_K:
         begin
            cg_d = lcd_pkg::CG_K;
            ts_d = lcd_pkg::TS_DATA;
         end
         lcd_pkg::TS_DATA:
            if (!tx_en_eff)
            begin
               cg_d = lcd_pkg::CG_T;
               ts_d = lcd_pkg::TS_R;
            end
            else if (tx_er_in && !er_prev_q)
               cg_d = lcd_pkg::CG_H;
            else
               cg_d = lcd_pkg::CG_TAB[txd_in];
         lcd_pkg::TS_R:
         begin
            cg_d = lcd_pkg::CG_R;
            ts_d = lcd_pkg::TS_IDLE;
         end
         default:
            ts_d = lcd_pkg::TS_IDLE;
      endcase
   end

   // 100M transmit: shift, scramble, NRZI, MLT-3
   logic [4:0]  tsh_q;
   logic [10:0] tkey_q;
   logic        tkey, tbit, tnrzi_q, tnrzi_p_q, pos_q, neg_q;
   logic [1:0]  mlt_q, mlt_d;
   assign tkey  = tkey_q[lcd_pkg::SCR_TAP_A] ^ tkey_q[lcd_pkg::SCR_TAP_B];
   assign tbit  = tsh_q[4] ^ tkey;
   assign mlt_d = (tnrzi_q != tnrzi_p_q) ? mlt_q + 2'h1 : mlt_q;
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         ts_q      <= lcd_pkg::TS_IDLE;
         er_prev_q <= 1'b0;
         tsh_q     <= lcd_pkg::CG_IDLE;
         tkey_q    <= lcd_pkg::SCR_SEED;
         tnrzi_q   <= 1'b0;
         tnrzi_p_q <= 1'b0;
         mlt_q     <= 2'h0;
         pos_q     <= 1'b0;
         neg_q     <= 1'b0;
      end
      else
      begin
         if (nib_last && speed_100_in)
         begin
            ts_q      <= ts_d;
            er_prev_q <= tx_er_in;
            tsh_q     <= cg_d;
         end
         else
            tsh_q <= {tsh_q[3:0], 1'b0};
         tkey_q    <= {tkey_q[9:0], tkey};
         tnrzi_q   <= tnrzi_q ^ tbit;
         tnrzi_p_q <= tnrzi_q;
         mlt_q     <= mlt_d;
         pos_q     <= speed_100_in && (mlt_d == 2'h1);
         neg_q     <= speed_100_in && (mlt_d == 2'h3);
      end
   assign mlt3_pos_out = pos_q;
   assign mlt3_neg_out = neg_q;

   // 100M receive: slicing, NRZI, descrambling
   logic signed [5:0] smp_s;
   logic [1:0]  lvl, rlvl_q;
   logic        rnrzi_q, rnrzi_p_q, rbit, dpred, plain, locked_q, idle_seen, abort_q;
   logic [10:0] dkey_q;
   logic [5:0]  mcnt_q;
   logic [31:0] tmo_q;
   logic [3:0]  run_q;
   logic [14:0] win_q;
   assign smp_s = smp_q;
   assign lvl   = (smp_s > lcd_pkg::MLT_THR) ? 2'h1 :
                  (smp_s < -lcd_pkg::MLT_THR) ? 2'h3 : 2'h0;
   assign rbit  = rnrzi_q ^ rnrzi_p_q;
   assign dpred = dkey_q[lcd_pkg::SCR_TAP_A] ^ dkey_q[lcd_pkg::SCR_TAP_B];
   assign plain = descr_bypass_in ? rbit : rbit ^ dpred;
   assign idle_seen = run_q >= lcd_pkg::IDLE_RUN;
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         rlvl_q    <= 2'h0;
         rnrzi_q   <= 1'b0;
         rnrzi_p_q <= 1'b0;
         dkey_q    <= lcd_pkg::SCR_SEED;
         mcnt_q    <= 6'h00;
         locked_q  <= 1'b0;
         tmo_q     <= 32'h0;
         abort_q   <= 1'b0;
         run_q     <= 4'h0;
         win_q     <= 15'h0000;
      end
      else
      begin
         rlvl_q    <= lvl;
         rnrzi_q   <= rnrzi_q ^ (lvl != rlvl_q);
         rnrzi_p_q <= rnrzi_q;
         win_q     <= {win_q[13:0], plain};
         run_q     <= !plain ? 4'h0 : idle_seen ? run_q : run_q + 4'h1;
         abort_q   <= 1'b0;
         if (!locked_q)
         begin
            // Idle carries all ones, so the line bit inverted is the key
            dkey_q <= {dkey_q[9:0], ~rbit};
            mcnt_q <= (~rbit == dpred) ? mcnt_q + 6'h01 : 6'h00;
            locked_q <= (mcnt_q == lcd_pkg::LOCK_MATCHES);
            tmo_q  <= 32'h0;
         end
         else
         begin
            dkey_q <= {dkey_q[9:0], dpred};
            if (idle_seen)
               tmo_q <= 32'h0;
            else if (tmo_q == 32'(lcd_pkg::SYNC_TIMEOUT_CYC - 1))
            begin
               locked_q <= 1'b0;
               mcnt_q   <= 6'h00;
               abort_q  <= 1'b1;
               tmo_q    <= 32'h0;
            end
            else
               tmo_q <= tmo_q + 32'h1;
         end
      end
   assign descr_locked_out = locked_q;

   // 10M receive: polarity, link pulses, Manchester decode
   logic        act, lv, prev_lv_q, plvl_q, pol_q, up_q, started_q, r10_rdy_q, mid;
   logic [31:0] act_cnt_q, lcnt_q;
   logic [1:0]  smid_q, bcnt_q;
   logic [3:0]  n10_q;
   assign act = l10_q[1];
   assign lv  = l10_q[0] ^ pol_q;
   // Level seen before squelch opened is stale, so the first active sample is no edge
   assign mid = act && act_cnt_q != 32'h0 && (lv != prev_lv_q) &&
                (!started_q || smid_q != 2'h0);
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         prev_lv_q <= 1'b0;
         plvl_q    <= 1'b0;
         pol_q     <= 1'b0;
         up_q      <= 1'b0;
         act_cnt_q <= 32'h0;
         lcnt_q    <= 32'h0;
         started_q <= 1'b0;
         smid_q    <= 2'h0;
         bcnt_q    <= 2'h0;
         n10_q     <= 4'h0;
         r10_rdy_q <= 1'b0;
      end
      else
      begin
         prev_lv_q <= lv;
         r10_rdy_q <= 1'b0;
         if (act)
         begin
            act_cnt_q <= act_cnt_q + 32'h1;
            plvl_q    <= l10_q[0];
         end
         else
            act_cnt_q <= 32'h0;
         if (!act && act_cnt_q != 32'h0)
         begin
            // A short burst is a link pulse; its sign reveals a swapped pair
            if (act_cnt_q <= 32'(lcd_pkg::PULSE_MAX_CYC))
               pol_q <= ~plvl_q;
            lcnt_q <= 32'h0;
            up_q   <= 1'b1;
         end
         else if (lcnt_q == 32'(LINK_LOSS_CYC - 1))
            up_q <= 1'b0;
         else
            lcnt_q <= lcnt_q + 32'h1;
         if (!act)
         begin
            started_q <= 1'b0;
            bcnt_q    <= 2'h0;
            smid_q    <= 2'h0;
         end
         else if (mid)
         begin
            started_q <= 1'b1;
            smid_q    <= 2'h0;
            n10_q     <= {lv, n10_q[3:1]};
            bcnt_q    <= bcnt_q + 2'h1;
            r10_rdy_q <= (bcnt_q == 2'h3);
         end
         else if (smid_q != 2'h3)
            smid_q <= smid_q + 2'h1;
      end
   assign polarity_reversed_flag_out = pol_q;
   assign link10_up_out              = up_q;

   // Receive MII outputs, 100M framing and 5B/4B decoding
   logic       rf_q, t_seen_q, i_seen_q, sec_q, stb_q, dv_q, er_q, crs_q;
   logic [2:0] rph_q;
   logic [3:0] rxd_q;
   logic [4:0] dg;
   assign dg = dec5(win_q[4:0]);
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         rf_q     <= 1'b0;
         t_seen_q <= 1'b0;
         i_seen_q <= 1'b0;
         sec_q    <= 1'b0;
         rph_q    <= 3'h0;
         stb_q    <= 1'b0;
         dv_q     <= 1'b0;
         er_q     <= 1'b0;
         crs_q    <= 1'b0;
         rxd_q    <= 4'h0;
      end
      else
      begin
         stb_q <= 1'b0;
         er_q  <= 1'b0;
         sec_q <= 1'b0;
         if (!speed_100_in)
         begin
            rf_q  <= 1'b0;
            dv_q  <= started_q;
            crs_q <= act && act_cnt_q > 32'(lcd_pkg::PULSE_MAX_CYC);
            stb_q <= r10_rdy_q;
            if (r10_rdy_q)
               rxd_q <= n10_q;
         end
         else if (abort_q || (!locked_q && !descr_bypass_in))
         begin
            rf_q  <= 1'b0;
            dv_q  <= 1'b0;
            crs_q <= 1'b0;
         end
         else if (!rf_q)
         begin
            dv_q  <= 1'b0;
            crs_q <= 1'b0;
            // Delimiter pair counts only right after an idle group
            if (win_q == {lcd_pkg::CG_IDLE, lcd_pkg::CG_J, lcd_pkg::CG_K})
            begin
               rf_q     <= 1'b1;
               dv_q     <= 1'b1;
               crs_q    <= 1'b1;
               stb_q    <= 1'b1;
               rxd_q    <= lcd_pkg::START_NIB;
               sec_q    <= 1'b1;
               rph_q    <= 3'h0;
               t_seen_q <= 1'b0;
               i_seen_q <= 1'b0;
            end
         end
         else
         begin
            if (sec_q)
            begin
               stb_q <= 1'b1;
               rxd_q <= lcd_pkg::START_NIB;
            end
            rph_q <= (rph_q == 3'h4) ? 3'h0 : rph_q + 3'h1;
            if (rph_q == 3'h4)
            begin
               if (t_seen_q)
               begin
                  rf_q  <= 1'b0;
                  dv_q  <= 1'b0;
                  crs_q <= 1'b0;
                  er_q  <= win_q[4:0] != lcd_pkg::CG_R;
               end
               else if (win_q[4:0] == lcd_pkg::CG_T)
                  t_seen_q <= 1'b1;
               else if (win_q[4:0] == lcd_pkg::CG_IDLE)
               begin
                  i_seen_q <= 1'b1;
                  if (i_seen_q)
                  begin
                     rf_q  <= 1'b0;
                     dv_q  <= 1'b0;
                     crs_q <= 1'b0;
                  end
               end
               else
               begin
                  // J, K, R or H in mid-frame decode as invalid
                  i_seen_q <= 1'b0;
                  stb_q    <= 1'b1;
                  rxd_q    <= dg[3:0];
                  er_q     <= !dg[4];
               end
            end
         end
      end
   assign rxd_out        = rxd_q;
   assign rx_dv_out      = dv_q;
   assign rx_er_out      = er_q;
   assign rx_nib_stb_out = stb_q;
   assign crs_out        = crs_q;

   // 10M transmit: Manchester data or link pulses
   logic [3:0]  sh10_q;
   logic        on10_q, line_q, drv_q, man;
   logic [31:0] ncnt_q;
   // First half carries the inverse, second half the bit itself
   assign man = nib_cnt_q[0] ? sh10_q[nib_cnt_q[2:1]] : ~sh10_q[nib_cnt_q[2:1]];
   always_ff @(posedge clk_in or posedge sys_rst_in)
      if (sys_rst_in)
      begin
         sh10_q <= 4'h0;
         on10_q <= 1'b0;
         ncnt_q <= 32'h0;
         line_q <= 1'b0;
         drv_q  <= 1'b0;
      end
      else
      begin
         if (nib_last)
         begin
            on10_q <= !speed_100_in && tx_en_eff;
            sh10_q <= txd_in;
         end
         ncnt_q <= (on10_q || ncnt_q == 32'(PULSE_PERIOD_CYC - 1)) ? 32'h0 : ncnt_q + 32'h1;
         if (speed_100_in)
         begin
            line_q <= 1'b0;
            drv_q  <= 1'b0;
         end
         else if (on10_q)
         begin
            line_q <= man;
            drv_q  <= 1'b1;
         end
         else
         begin
            line_q <= ncnt_q < 32'(lcd_pkg::PULSE_WIDTH_CYC);
            drv_q  <= ncnt_q < 32'(lcd_pkg::PULSE_WIDTH_CYC);
         end
      end
   assign tx10_line_out  = line_q;
   assign tx10_drive_out = drv_q;
endmodule

/* testbench/lcd_datapath_assertions.sv */
// Purpose: Port-level assertions for the line-coding datapath
// Assumes: Speed is only changed while reset is held
// Notes:   Jabber bound allows two cycles of register delay
`timescale 1ns/1ns
module lcd_datapath_checker #(
   parameter int JABBER_CYC = 50
)(
   input wire logic       clk_in,
   input wire logic       sys_rst_in,
   input wire logic       speed_100_in,
   input wire logic       descr_bypass_in,
   input wire logic       tx_en_in,
   input wire logic       tx_nib_take_out,
   input wire logic       mlt3_pos_out,
   input wire logic       mlt3_neg_out,
   input wire logic [3:0] rxd_out,
   input wire logic       rx_dv_out,
   input wire logic       rx_nib_stb_out,
   input wire logic       crs_out,
   input wire logic       polarity_reversed_flag_out,
   input wire logic       jabber_out,
   input wire logic       descr_locked_out
);
   int unsigned en_cnt_q;

   // Cycles of unbroken transmit enable
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         en_cnt_q <= 0;
      else
         en_cnt_q <= tx_en_in ? en_cnt_q + 1 : 0;
   end

   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   mlt3_excl_a: assert property (!(mlt3_pos_out && mlt3_neg_out))
      else $error("both line levels active");
   mlt3_step_a: assert property ((mlt3_pos_out |=> !mlt3_neg_out)
      and (mlt3_neg_out |=> !mlt3_pos_out)) else $error("line level skipped zero");
   mlt3_quiet_a: assert property (!speed_100_in |-> !mlt3_pos_out && !mlt3_neg_out)
      else $error("three-level line active at 10M");
   take_fast_a: assert property (tx_nib_take_out && speed_100_in
      |=> !tx_nib_take_out [*4] ##1 tx_nib_take_out) else $error("100M take period");
   take_slow_a: assert property (tx_nib_take_out && !speed_100_in
      |=> !tx_nib_take_out [*7] ##1 tx_nib_take_out) else $error("10M take period");
   start_pair_a: assert property ($rose(rx_dv_out) && speed_100_in
      |-> (rx_nib_stb_out && rxd_out == 4'h5 && crs_out)
      ##1 (rx_nib_stb_out && rxd_out == 4'h5)) else $error("frame start nibbles");
   lock_first_a: assert property ($rose(rx_dv_out) && speed_100_in
      |-> descr_locked_out || descr_bypass_in) else $error("frame while unlocked");
   dv_carrier_a: assert property (speed_100_in && rx_dv_out |-> crs_out)
      else $error("valid without carrier");
   jabber_cut_a: assert property (en_cnt_q > JABBER_CYC + 1 |-> jabber_out)
      else $error("jabber not cut");
   jabber_clear_a: assert property (!tx_en_in |=> !jabber_out)
      else $error("jabber held after enable low");

   cover property ($rose(rx_dv_out));
   cover property ($rose(jabber_out));
   cover property ($rose(polarity_reversed_flag_out));
endmodule

bind lcd_datapath lcd_datapath_checker #(.JABBER_CYC(JABBER_CYC)) u_chk (
   .clk_in, .sys_rst_in, .speed_100_in, .descr_bypass_in, .tx_en_in, .tx_nib_take_out,
   .mlt3_pos_out, .mlt3_neg_out, .rxd_out, .rx_dv_out, .rx_nib_stb_out, .crs_out,
   .polarity_reversed_flag_out, .jabber_out, .descr_locked_out
);

/* testbench/lcd_mac_model.sv */
// Purpose: Transmit side of the MAC facing the datapath
// Assumes: Nibbles change only after the edge that took them
// Notes:   hold keeps enable up for jabber runs
`timescale 1ns/1ns
module lcd_mac_model (
   input  wire logic clk_in,
   input  wire logic take_in,
   output logic      tx_en_out,
   output logic      tx_er_out,
   output logic [3:0] txd_out
);
   int seed  = 88097;
   int left  = 0;
   int er_at = -1;
   bit hold  = 1'b0;

   initial
   begin
      tx_en_out = 1'b0;
      tx_er_out = 1'b0;
      txd_out   = 4'h0;
   end

   task automatic send(input int n, input bit e);
      left  = n;
      er_at = e ? n / 2 : -1;
   endtask

   always @(posedge clk_in)
   begin
      if (take_in)
      begin
         #1;
         tx_en_out = left > 0;
         tx_er_out = left == er_at;
         txd_out   = 4'($random(seed));
         if (left > 0 && !hold)
            left = left - 1;
      end
   end
endmodule

/* testbench/test_lcd_datapath.sv */
// Purpose: Self-checking bench for the line-coding datapath
// Assumes: 100M line looped back through a slicer model
// Notes:   10M line looped back directly; data, link and polarity compared
`timescale 1ns/1ns
module test_lcd_datapath;
   logic       clk_in = 1'b0, sys_rst_in = 1'b1, speed_100_in = 1'b1;
   logic       descr_bypass_in = 1'b0, rx10_line_in = 1'b0, rx10_active_in = 1'b0;
   logic       inv = 1'b0, mon = 1'b1;
   logic [5:0] rx_sample_in = 6'h00;
   logic       tx_en_in, tx_er_in, tx_nib_take_out, mlt3_pos_out, mlt3_neg_out;
   logic       tx10_line_out, tx10_drive_out, rx_dv_out, rx_er_out, rx_nib_stb_out;
   logic       crs_out, polarity_reversed_flag_out, link10_up_out, jabber_out;
   logic       descr_locked_out;
   logic [3:0] txd_in, rxd_out;
   logic [3:0] exp_q [$];
   int         failures = 0, compares = 0, pre = 0, er_seen = 0;
   int         lens [3] = '{3, 16, 40};

   always #25 clk_in = ~clk_in;

   // Jabber limit above the longest test frame, so only the jabber scenario trips it
   lcd_datapath #(.JABBER_CYC(300), .PULSE_PERIOD_CYC(40), .LINK_LOSS_CYC(200)) u_dut (
      .clk_in, .sys_rst_in, .speed_100_in, .descr_bypass_in, .tx_en_in, .tx_er_in,
      .txd_in, .rx_sample_in, .rx10_line_in, .rx10_active_in, .tx_nib_take_out,
      .mlt3_pos_out, .mlt3_neg_out, .tx10_line_out, .tx10_drive_out, .rxd_out,
      .rx_dv_out, .rx_er_out, .rx_nib_stb_out, .crs_out, .polarity_reversed_flag_out,
      .link10_up_out, .jabber_out, .descr_locked_out);

   lcd_mac_model u_mac (.clk_in, .take_in(tx_nib_take_out), .tx_en_out(tx_en_in),
      .tx_er_out(tx_er_in), .txd_out(txd_in));

   // Released 10M line toggles so a stale level is never mistaken for data
   always @(posedge clk_in)
   begin
      #1;
      rx_sample_in   = mlt3_pos_out ? 6'h14 : mlt3_neg_out ? 6'h2C : 6'h00;
      rx10_active_in = tx10_drive_out;
      rx10_line_in   = tx10_drive_out ? tx10_line_out ^ inv : ~rx10_line_in;
   end

   task automatic conclude();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check_nib(input logic [3:0] e, input logic [3:0] s);
      compares++;
      if (s !== e)
      begin
         failures++;
         $display("mismatch rxd expected %h seen %h", e, s);
      end
   endtask

   task automatic check_bit(input string n, input logic e, input logic s);
      compares++;
      if (s !== e)
      begin
         failures++;
         $display("mismatch %s expected %b seen %b", n, e, s);
      end
   endtask

   function automatic bit met(input int sel);
      case (sel)
         0: return descr_locked_out === 1'b1;
         1: return rx_dv_out === 1'b1;
         2: return rx_dv_out === 1'b0;
         3: return jabber_out === 1'b1;
         4: return jabber_out === 1'b0;
         5: return link10_up_out === 1'b1;
         default: return polarity_reversed_flag_out === 1'b1;
      endcase
   endfunction

   task automatic await(input int lim, input int sel);
      int i;
      for (i = 0; i < lim && !met(sel); i++)
         @(negedge clk_in);
      check_bit("wait done", 1'b1, met(sel));
      if (!met(sel))
         conclude();
   endtask

   task automatic reset_to(input logic sp);
      @(posedge clk_in);
      #1;
      sys_rst_in   = 1'b1;
      speed_100_in = sp;
      repeat (6) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
   endtask

   // Model: at 100M the first two nibbles of a frame come back as the delimiter value
   always @(negedge clk_in)
   begin
      if (tx_nib_take_out)
      begin
         if (!tx_en_in)
            pre = 0;
         else
         begin
            if (mon)
               exp_q.push_back((pre < 2 && speed_100_in) ? 4'h5 : txd_in);
            pre++;
         end
      end
      if (rx_er_out)
         er_seen++;
      if (rx_nib_stb_out && mon)
      begin
         check_nib(exp_q.size() ? exp_q.pop_front() : 4'hX, rxd_out);
         check_bit("rx_dv", 1'b1, rx_dv_out);
      end
   end

   initial
   begin
      reset_to(1'b1);
      await(3000, 0);
      for (int f = 0; f < 3; f++)
      begin
         u_mac.send(lens[f], 1'b0);
         await(2000, 1);
         await(2000, 2);
         check_bit("all nibbles", 1'b1, exp_q.size() == 0);
         check_bit("crs", 1'b0, crs_out);
      end
      mon = 1'b0;
      u_mac.send(12, 1'b1);
      await(2000, 1);
      await(2000, 2);
      check_bit("rx_er", 1'b1, er_seen > 0);
      u_mac.hold = 1'b1;
      u_mac.send(1, 1'b0);
      await(700, 3);
      u_mac.hold = 1'b0;
      await(50, 4);
      reset_to(1'b0);
      await(300, 5);
      mon = 1'b1;
      u_mac.send(5, 1'b0);
      await(600, 1);
      await(600, 2);
      check_bit("all nibbles", 1'b1, exp_q.size() == 0);
      check_bit("crs", 1'b0, crs_out);
      check_bit("polarity", 1'b0, polarity_reversed_flag_out);
      inv = 1'b1;
      await(600, 6);
      conclude();
   end
endmodule
